// ===== core/mia_core.v
/*
 * maskable interrupt acceptance: per-source control registers, pin edge
 * detection, global enable, processor level and the acceptance decision.
 * assumes pins and the core's acknowledge are synchronous to pclk.
 */
`timescale 1ns/10ps
`include "mia_defines.vh"

module mia_core (
    pclk,
    presetn,
    clk_en,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    int_pin,
    cpu_ack,
    int_request,
    int_source,
    int_level,
    irq
);
    input                        pclk;
    input                        presetn;
    input                        clk_en;
    input                        psel;
    input                        penable;
    input                        pwrite;
    input  [`MIA_ADDR_W-1:0]     paddr;
    input  [31:0]                pwdata;
    output [31:0]                prdata;
    output                       pready;
    output                       pslverr;
    input  [`MIA_NSRC-1:0]       int_pin;
    input                        cpu_ack;
    output                       int_request;
    output [1:0]                 int_source;
    output [2:0]                 int_level;
    output                       irq;

    reg    [31:0]                prdata_reg;
    reg                          pready_reg;
    reg                          pslverr_reg;
    reg    [2:0]                 lvl_reg [0:`MIA_NSRC-1];
    reg    [`MIA_NSRC-1:0]       pend_reg;
    reg    [`MIA_NSRC-1:0]       pol_reg;
    reg    [`MIA_NSRC-1:0]       pin_reg;
    reg                          gen_reg;
    reg    [2:0]                 plevel_reg;
    reg                          req_reg;
    reg    [1:0]                 src_reg;
    reg    [2:0]                 reqlvl_reg;
    reg    [`MIA_EV_W-1:0]       stat_reg;
    reg    [`MIA_EV_W-1:0]       ien_reg;
    reg                          irq_reg;

    wire                         acc_phase;
    wire                         wr_en;
    wire   [`MIA_NSRC-1:0]       edge_hit;
    wire                         win_valid;
    wire   [1:0]                 win_id;
    wire   [2:0]                 win_lvl;
    wire                         take;
    wire                         ev_pend;

    // address to control register index, or -1 when not a control reg
    function integer ctrl_index;
        input [`MIA_ADDR_W-1:0] a;
        begin
            if (a >= `MIA_OFS_CTRL0 && a <= `MIA_OFS_CTRL3 &&
                a[1:0] == 2'h0) begin
                ctrl_index = a[3:2];
            end else begin
                ctrl_index = -1;
            end
        end
    endfunction

    function mapped;
        input [`MIA_ADDR_W-1:0] a;
        begin
            if (ctrl_index(a) >= 0) begin
                mapped = 1'b1;
            end else if (a == `MIA_OFS_GLOBAL || a == `MIA_OFS_PLEVEL ||
                         a == `MIA_OFS_ACCEPT || a == `MIA_OFS_STATUS ||
                         a == `MIA_OFS_CLEAR  || a == `MIA_OFS_ENABLE) begin
                mapped = 1'b1;
            end else begin
                mapped = 1'b0;
            end
        end
    endfunction

    // pready follows the first access edge; a write lands only on the
    // edge where the master samples pready high, never before it
    assign acc_phase = psel & penable & ~pready_reg;
    assign wr_en     = psel & penable & pready_reg & pwrite & clk_en &
                       mapped(paddr);

    // pin edge detection per polarity; one set per edge
    genvar g;
    generate
        for (g = 0; g < `MIA_NSRC; g = g + 1) begin : g_edge
            assign edge_hit[g] = pol_reg[g] ?
                (int_pin[g] & ~pin_reg[g]) :
                (~int_pin[g] & pin_reg[g]);
        end
    endgenerate

    // priority search: lowest index wins on ties since only strict
    // greater levels replace the running best
    reg                          best_v;
    reg    [1:0]                 best_i;
    reg    [2:0]                 best_l;
    integer k;
    always @* begin
        best_v = 1'b0;
        best_i = 2'h0;
        best_l = `MIA_LVL_ZERO;
        for (k = 0; k < `MIA_NSRC; k = k + 1) begin
            // level 0 is disabled; must beat processor level
            if (pend_reg[k] && lvl_reg[k] > plevel_reg &&
                lvl_reg[k] != `MIA_LVL_ZERO &&
                (!best_v || lvl_reg[k] > best_l)) begin
                best_v = 1'b1;
                best_i = k[1:0];
                best_l = lvl_reg[k];
            end
        end
    end
    assign win_valid = best_v & gen_reg;
    assign win_id    = best_i;
    assign win_lvl   = best_l;
    assign take      = req_reg & cpu_ack;
    assign ev_pend   = |edge_hit;

    // sources: pending, priority, polarity, pin history
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= {`MIA_NSRC{1'b0}};
            pol_reg  <= {`MIA_NSRC{1'b0}};
            pin_reg  <= {`MIA_NSRC{1'b0}};
            for (i = 0; i < `MIA_NSRC; i = i + 1) begin
                lvl_reg[i] <= `MIA_LVL_ZERO;
            end
        end else if (clk_en) begin
            pin_reg <= int_pin;
            for (i = 0; i < `MIA_NSRC; i = i + 1) begin
                if (wr_en && ctrl_index(paddr) == i) begin
                    // independent fields in one word
                    lvl_reg[i] <= pwdata[`MIA_LVL_MSB:`MIA_LVL_LSB];
                    pol_reg[i] <= pwdata[`MIA_POL_BIT];
                end
                if (edge_hit[i]) begin
                    pend_reg[i] <= 1'b1;  // set beats any clear
                end else if (take && src_reg == i) begin
                    pend_reg[i] <= 1'b0;
                end else if (wr_en && ctrl_index(paddr) == i &&
                             !pwdata[`MIA_PEND_BIT]) begin
                    pend_reg[i] <= 1'b0;  // a written 1 is ignored
                end
            end
        end
    end

    // global enable and processor level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_reg    <= 1'b0;
            plevel_reg <= `MIA_LVL_ZERO;
        end else if (clk_en) begin
            if (take) begin
                plevel_reg <= reqlvl_reg;
            end else if (wr_en && paddr == `MIA_OFS_PLEVEL) begin
                plevel_reg <= pwdata[2:0];
            end
            if (wr_en && paddr == `MIA_OFS_GLOBAL) begin
                gen_reg <= pwdata[0];
            end
        end
    end

    // request to the core, re-evaluated every cycle until acknowledged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg    <= 1'b0;
            src_reg    <= 2'h0;
            reqlvl_reg <= `MIA_LVL_ZERO;
        end else if (clk_en) begin
            if (take) begin
                req_reg <= 1'b0;
            end else begin
                // re-evaluated every cycle: a masked source drops out
                req_reg    <= win_valid;
                src_reg    <= win_id;
                reqlvl_reg <= win_lvl;
            end
        end
    end

    // sticky events; hardware set wins over the clear write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= {`MIA_EV_W{1'b0}};
            ien_reg  <= {`MIA_EV_W{1'b0}};
            irq_reg  <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && paddr == `MIA_OFS_ENABLE) begin
                ien_reg <= pwdata[`MIA_EV_W-1:0];
            end
            if (wr_en && paddr == `MIA_OFS_CLEAR) begin
                stat_reg <= (stat_reg & ~pwdata[`MIA_EV_W-1:0]) |
                            {ev_pend, take};
            end else begin
                stat_reg <= stat_reg | {ev_pend, take};
            end
            irq_reg <= |(stat_reg & ien_reg);
        end
    end

    // apb read mux and answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (clk_en) begin
            pready_reg  <= acc_phase;
            pslverr_reg <= acc_phase & ~mapped(paddr);
            prdata_reg  <= 32'h00000000;
            if (acc_phase && !pwrite) begin
                if (ctrl_index(paddr) >= 0) begin
                    // unassigned bits stay zero
                    prdata_reg[`MIA_CTRL_W-1:0] <= {
                        pol_reg[paddr[3:2]], pend_reg[paddr[3:2]],
                        lvl_reg[paddr[3:2]]};
                end else if (paddr == `MIA_OFS_GLOBAL) begin
                    prdata_reg[0] <= gen_reg;
                end else if (paddr == `MIA_OFS_PLEVEL) begin
                    prdata_reg[2:0] <= plevel_reg;
                end else if (paddr == `MIA_OFS_ACCEPT) begin
                    prdata_reg[`MIA_ACC_VALID] <= req_reg;
                    prdata_reg[`MIA_ACC_ID_MSB:0] <= src_reg;
                end else if (paddr == `MIA_OFS_STATUS) begin
                    prdata_reg[`MIA_EV_W-1:0] <= stat_reg;
                end else if (paddr == `MIA_OFS_ENABLE) begin
                    prdata_reg[`MIA_EV_W-1:0] <= ien_reg;
                end
            end
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign int_request = req_reg;
    assign int_source  = src_reg;
    assign int_level   = reqlvl_reg;
    assign irq         = irq_reg;
endmodule

// ===== core/mia_defines.vh
/*
 * register map, field layout and sizes for the maskable interrupt
 * acceptance block. assumes an apb slave with 32-bit data, word aligned.
 */
// Overview of operation
// - a raised source request sets its pending bit in hardware
// - accepted and vectored request clears its pending bit in hardware
// - software may clear pending by writing 0; writing 1 never sets it
// - edge polarity 0 selects falling edge, 1 selects rising edge
// - unassigned control bits read as 0; software writes 0 there
// - one global enable flag gates all maskable sources together
// - reset clears the global enable flag to 0
// - 3-bit priority: 000 disabled, 001 to 111 levels 1 to 7
// - accept only if enable, pending and level above processor level
// - processor level n passes levels above n; 111 blocks all
// - enable, pending, priority and processor level stored independently
// - pending raised during a rewrite is kept by the hardware
// - equal levels resolve to the lower-numbered source
// - acceptance loads processor level with the accepted level
`ifndef MIA_DEFINES_VH
`define MIA_DEFINES_VH

`define MIA_NSRC        4
`define MIA_ADDR_W      8
// register byte offsets
`define MIA_OFS_CTRL0   8'h00
`define MIA_OFS_CTRL3   8'h0C
`define MIA_OFS_GLOBAL  8'h10
`define MIA_OFS_PLEVEL  8'h14
`define MIA_OFS_ACCEPT  8'h18
`define MIA_OFS_STATUS  8'h1C
`define MIA_OFS_CLEAR   8'h20
`define MIA_OFS_ENABLE  8'h24
// control register fields
`define MIA_LVL_LSB     0
`define MIA_LVL_MSB     2
`define MIA_PEND_BIT    3
`define MIA_POL_BIT     4
`define MIA_CTRL_W      5
// accept register fields
`define MIA_ACC_VALID   31
`define MIA_ACC_ID_MSB  1
// status event bits
`define MIA_EV_ACCEPT   0
`define MIA_EV_PEND     1
`define MIA_EV_W        2
`define MIA_LVL_ZERO    3'h0
`define MIA_LVL_MAX     3'h7

`endif

// ===== sim/mia_core_assertions.sv
/* port checks for mia_core: apb answer, acceptance gating and masking.
   assumes the hand-over timing: registered outputs, one-cycle pready. */
`timescale 1ns/10ps
`include "mia_defines.vh"
module mia_core_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_ack,
    input wire logic        int_request,
    input wire logic [2:0]  int_level,
    input wire logic        irq
);
    logic [2:0] plvl_reg;
    logic       gen_reg;
    wire        wr_take = psel && penable && pwrite && pready && clk_en &&
                          !pslverr;
    wire        acc_take = int_request && cpu_ack && clk_en;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // shadow of processor level and global enable, seen from the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            plvl_reg <= 3'h0;
            gen_reg  <= 1'b0;
        end else begin
            if (wr_take && paddr == `MIA_OFS_PLEVEL)
                plvl_reg <= pwdata[2:0];
            else if (acc_take)
                plvl_reg <= int_level;
            if (wr_take && paddr == `MIA_OFS_GLOBAL)
                gen_reg <= pwdata[0];
        end
    end

    // request goes stale one cycle after a change, so gate with $stable
    chk_apb_answer: assert property (psel && penable && !pready && clk_en
        |=> pready) else $error("pready missing after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_reset_quiet: assert property ($rose(presetn) |->
        !int_request && !irq && !pready) else $error("busy after reset");
    chk_level_nonzero: assert property (int_request |->
        int_level != `MIA_LVL_ZERO) else $error("level zero offered");
    chk_ack_drop: assert property (acc_take |=> !int_request)
        else $error("request held after acceptance");
    chk_global_gate: assert property (int_request && $stable(gen_reg)
        |-> gen_reg) else $error("request with global enable clear");
    chk_level_mask: assert property (int_request && $stable(plvl_reg)
        |-> int_level > plvl_reg) else $error("level not above threshold");
endmodule

bind mia_core mia_core_assertions i_mia_core_assertions (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .cpu_ack(cpu_ack),
    .int_request(int_request), .int_level(int_level), .irq(irq));

// ===== sim/mia_cpu_model.sv
/* processor core stand-in: takes offered requests after a set delay.
   assumes int_request is a registered level from mia_core. */
`timescale 1ns/10ps
module mia_cpu_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       int_request,
    input  wire logic [1:0] ack_delay,
    output logic            cpu_ack
);
    logic [1:0] wait_reg;

    // ack only while offered; a masked request restarts the wait
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 2'h0;
            cpu_ack  <= 1'b0;
        end else begin
            cpu_ack <= int_request && !cpu_ack && wait_reg == ack_delay;
            if (!int_request || cpu_ack)
                wait_reg <= 2'h0;
            else if (wait_reg != ack_delay)
                wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// ===== sim/tb.sv
/* self-checking bench for mia_core: apb master, pins, scoreboard.
   assumes mia_cpu_model as the core and the bound port checker. */
`timescale 1ns/10ps
`include "mia_defines.vh"
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  int_pin = 4'h0;
    logic [1:0]  ack_delay = 2'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         cpu_ack;
    wire         int_request;
    wire         irq;
    wire  [1:0]  int_source;
    wire  [2:0]  int_level;
    logic [32:0] rd_q[$];
    logic [4:0]  acc_q[$];
    int          failures = 0;
    int          check_count = 0;
    int          i;
    int          n;
    logic [2:0]  lv;
    logic        pl;

    always #2 pclk = ~pclk;

    mia_core i_mia_core (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_pin(int_pin), .cpu_ack(cpu_ack),
        .int_request(int_request), .int_source(int_source),
        .int_level(int_level), .irq(irq));
    mia_cpu_model i_mia_cpu_model (.pclk(pclk), .presetn(presetn),
        .int_request(int_request), .ack_delay(ack_delay), .cpu_ack(cpu_ack));

    task automatic chk(input string what, input logic [32:0] e,
                       input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic hang;
        failures++;
        complete_run();
    endtask

    // one apb transfer; a read notes its expected answer first
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        if (!w) rd_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        if (!pready) hang();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    // wait for the noted acceptances, then show nothing more comes
    task automatic drain;
        n = 0;
        while (acc_q.size() != 0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (acc_q.size() != 0) hang();
        repeat (10) @(posedge pclk);
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // scoreboard: oldest note against each answer that appears
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready && !pwrite)
            chk("read", rd_q.pop_front(), {pslverr, prdata});
        if (presetn && int_request && cpu_ack)
            chk("accept", acc_q.pop_front(), {int_source, int_level});
    end

    initial begin
        repeat (20000) @(posedge pclk);
        hang();
    end

    initial begin
        void'($urandom(32'h444731B7));
        do_reset();
        // all places read zero after reset, the unmapped one errors
        for (i = 0; i < 11; i++)
            apb(1'b0, 8'(i * 4), 32'h0, {i == 10, 32'h0});
        // pin edges with global enable still clear
        for (i = 0; i < 4; i++) begin
            lv = 3'($urandom);
            pl = 1'($urandom);
            @(posedge pclk);
            int_pin[i] <= !pl;
            wr(8'(i * 4), {27'h0, pl, 1'b0, lv});
            int_pin[i] <= pl;
            repeat (4) @(posedge pclk);
            rd(8'(i * 4), {27'h0, pl, 1'b1, lv});
            wr(8'(i * 4), {27'h0, pl, 1'b0, lv});
            int_pin[i] <= !pl;
            repeat (4) @(posedge pclk);
            rd(8'(i * 4), {27'h0, pl, 1'b0, lv});
        end
        wr(`MIA_OFS_CTRL0, 32'h3);
        wr(8'h04, 32'h5);
        wr(8'h08, 32'h5);
        wr(`MIA_OFS_CTRL3, 32'h0);
        int_pin <= 4'hF;
        repeat (3) @(posedge pclk);
        int_pin <= 4'h0;
        repeat (8) @(posedge pclk);
        ack_delay <= 2'($urandom);
        acc_q.push_back({2'h1, 3'h5});
        wr(`MIA_OFS_GLOBAL, 32'h1);
        drain();
        rd(`MIA_OFS_PLEVEL, 32'h5);
        rd(8'h04, 32'h5);
        ack_delay <= 2'($urandom);
        acc_q.push_back({2'h2, 3'h5});
        wr(`MIA_OFS_PLEVEL, 32'h4);
        drain();
        acc_q.push_back({2'h0, 3'h3});
        wr(`MIA_OFS_PLEVEL, 32'h2);
        drain();
        rd(`MIA_OFS_CTRL3, 32'h8);
        rd(`MIA_OFS_STATUS, 32'h3);
        // irq: enable, mask, enable again, then clear the accept event
        for (i = 0; i < 4; i++) begin
            wr(i == 3 ? `MIA_OFS_CLEAR : `MIA_OFS_ENABLE, {31'h0, i != 1});
            repeat (3) @(posedge pclk);
            chk("irq", {32'h0, !i[0]}, {32'h0, irq});
        end
        rd(`MIA_OFS_STATUS, 32'h2);
        do_reset();
        rd(`MIA_OFS_GLOBAL, 32'h0);
        rd(8'h04, 32'h0);
        complete_run();
    end
endmodule
